// >>> rtl/nmc_core.sv
// Nibble core: sequencing, RAM, adder, ports and serial shift/count unit
// Functional notes
// [RULE1] 9-bit PC steps each cycle, 512 words
// [RULE2] Program store seen as 8 pages of 64
// [RULE3] Two 9-bit return saves form LIFO stack
// [RULE4] RAM is 4 rows of 8 digits
// [RULE5] Digit select MSB ignored for addressing
// [RULE6] Exchange-step skips on 0/15 wrap only
// [RULE7] 4-bit adder writes accumulator and carry
// [RULE8] Port latch drives 8 pins when enabled
// [RULE9] General register drives four I/O pins
// [RULE10] Swap acc with shift reg, carry to latch
// [RULE11] Enable register written only by load-enable
// [RULE12] Counter mode decrements on serial input fall
// [RULE13] Counter pulses last two cycles or more
// [RULE14] Counter mode: SO from bit3, clock=latch
// [RULE15] Shift mode shifts left, serial in LSB
// [RULE16] Shift mode clock is latch AND cycle clock
// [RULE17] Shift mode SO is MSB or zero
// [RULE18] Enable bit 1 does nothing
// [RULE19] Bit 2 enables 8-bit drivers, else hi-Z
// [RULE20] Reset held low three cycles externally
// [RULE21] Reset clears state, RAM kept; return saves, shift register and, on the reset pin, port latch also kept
// [RULE22] After reset clock pin is sync pulse
// [RULE23] Cycle is oscillator divided by 8 or 4
// [RULE24] Reset needs three consecutive low samples
`timescale 1ns/10ps
module nmc_core
    import nmc_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                divBy8,
    input  wire logic                resetPinN,
    input  wire nmc_pkg::nmc_instr_t instr,
    input  wire logic                instrValid,
    input  wire logic [7:0]          portPinIn,
    input  wire logic [3:0]          genPinIn,
    input  wire logic                serialInPin,
    output nmc_pkg::nmc_port8_t      portPins,
    output logic [3:0]               genPinOut,
    output logic [3:0]               genPinOe,
    output logic [3:0]               dataOut,
    output logic                     serialOutPin,
    output logic                     clock_out_pin,
    output logic [8:0]               romAddr,
    output logic                     skipNext,
    output logic                     cycleDone
);
    import nmc_pkg::*;

    logic       cycleStb;
    logic       halfHigh;
    logic       serialInSync;
    logic       resetPinSync;

    nmc_cycle_div u_div (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .divBy8   (divBy8),
        .cycleStb (cycleStb),
        .halfHigh (halfHigh)
    );

    nmc_sync3 u_si (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pinIn   (serialInPin),
        .level   (serialInSync)
    );

    nmc_sync3 u_rs (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pinIn   (resetPinN),
        .level   (resetPinSync)
    );

    // Parallel pin levels are crossed into the clock domain before any read
    logic [7:0] portPinSync;
    genvar      gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_port_sync
            nmc_sync3 u_ps (
                .clk_sys (clk_sys),
                .rst     (rst),
                .pinIn   (portPinIn[gi]),
                .level   (portPinSync[gi])
            );
        end
    endgenerate

    // Architectural state
    logic [8:0] pcReg;
    logic [8:0] return_save_first_reg;
    logic [8:0] return_save_second_reg;
    logic [3:0] accReg;
    logic [1:0] ram_row_select_reg;
    logic [3:0] digit_select_reg;
    logic       carryReg;
    logic [3:0] dataOutReg;
    logic [3:0] feature_enable_reg;
    logic [3:0] genReg;
    logic [7:0] portLatchReg;
    logic [3:0] shift_count_reg;
    logic       clock_out_latch_reg;
    logic       skipReg;
    logic [1:0] rstCntReg;
    logic       initReg;
    logic       siPrevReg;
    logic [3:0] ramMem [ROWS][DIGITS];

    // Reset pin counted per instruction cycle; initialisation after three lows
    wire lowSeen  = cycleStb && !resetPinSync;
    wire initTrig = lowSeen && (rstCntReg == 2'(RESET_LOW_CYCLES - 1)); // [RULE24] [RULE20]

    always_ff @(posedge clk_sys) begin
        if (rst || (cycleStb && resetPinSync)) begin
            rstCntReg <= 2'h0;
        end else if (lowSeen && rstCntReg != 2'(RESET_LOW_CYCLES - 1)) begin
            rstCntReg <= rstCntReg + 2'h1;
        end
    end

    wire doInit = rst || initTrig;
    wire step   = cycleStb && instrValid && !skipReg && !initReg;

    // Feature enable decoding; bit 1 deliberately unread
    wire cntMode  = feature_enable_reg[EN_CNT_BIT];
    wire portDrv  = feature_enable_reg[EN_LDRV_BIT]; // [RULE19]
    wire soEnable = feature_enable_reg[EN_SO_BIT];
    // [RULE18]

    // RAM addressing drops the digit select MSB
    wire [2:0] physDigit = digit_select_reg[2:0]; // [RULE5] [RULE4]
    wire [3:0] memNib    = ramMem[ram_row_select_reg][physDigit];

    // Adder shared by arithmetic operations
    wire       useCarry = (instr.op == OP_ASC);
    wire [3:0] addB     = (instr.op == OP_AISC) ? instr.imm : memNib;
    wire [4:0] addSum   = {1'b0, accReg} + {1'b0, addB} + {4'h0, useCarry && carryReg}; // [RULE7]

    // Digit select step for exchange-increment and -decrement
    wire [3:0] digitUp   = digit_select_reg + 4'h1;
    wire [3:0] digitDown = digit_select_reg - 4'h1;
    wire       wrapUp    = (digit_select_reg == NIB_MAX); // [RULE6]
    wire       wrapDown  = (digit_select_reg == NIB_ZERO); // [RULE6]

    // Control flow targets
    wire [8:0] pcInc    = pcReg + 9'h001; // [RULE1]
    wire [8:0] pagePc   = {pcReg[8:6], instr.addr[5:0]}; // [RULE2]
    wire [8:0] jsrpPc   = {JSRP_PAGE, instr.addr[5:0]}; // [RULE2]
    wire       isCall   = (instr.op == OP_JSR) || (instr.op == OP_JSRP);
    wire       isReturn = (instr.op == OP_RET) || (instr.op == OP_RETSK);

    logic [8:0] pcNext;
    logic       skipNext_next;
    always_comb begin
        pcNext        = pcInc;
        skipNext_next = 1'b0;
        case (instr.op)
            OP_JMP, OP_JSR: pcNext = instr.addr;
            OP_JP:          pcNext = pagePc;
            OP_JSRP:        pcNext = jsrpPc;
            OP_JID:         pcNext = {pcReg[8], instr.romData};
            OP_RET:         pcNext = return_save_first_reg; // [RULE3]
            OP_RETSK: begin
                pcNext        = return_save_first_reg;
                skipNext_next = 1'b1;
            end
            OP_ASC:         skipNext_next = addSum[4];
            OP_AISC:        skipNext_next = addSum[4];
            OP_XIS:         skipNext_next = wrapUp;
            OP_XDS:         skipNext_next = wrapDown;
            default:        pcNext = pcInc;
        endcase
    end

    // Sequencer: skipped cycles still advance the PC
    always_ff @(posedge clk_sys) begin
        if (doInit) begin
            pcReg   <= PC_RESET; // [RULE21]
            skipReg <= 1'b0;
        end else if (cycleStb && !initReg) begin
            pcReg   <= (step) ? pcNext : pcInc; // [RULE1]
            skipReg <= step && skipNext_next;
        end
    end

    // Return stack: push shifts first into second, pop reverses
    always_ff @(posedge clk_sys) begin
        if (step && isCall) begin
            return_save_second_reg <= return_save_first_reg; // [RULE3]
            return_save_first_reg  <= pcInc;
        end else if (step && isReturn) begin
            return_save_first_reg  <= return_save_second_reg; // [RULE3]
        end else if (step && instr.op == OP_LQID) begin
            return_save_second_reg <= return_save_first_reg;
        end
    end

    // Accumulator, carry, pointer
    always_ff @(posedge clk_sys) begin
        if (doInit) begin
            accReg             <= NIB_ZERO; // [RULE21]
            carryReg           <= 1'b0;
            ram_row_select_reg <= 2'h0;
            digit_select_reg   <= NIB_ZERO;
        end else if (step) begin
            case (instr.op)
                OP_ASC: begin
                    accReg   <= addSum[3:0]; // [RULE7]
                    carryReg <= addSum[4];
                end
                OP_ADD, OP_AISC: accReg <= addSum[3:0];
                OP_CLRA:         accReg <= NIB_ZERO;
                OP_COMP:         accReg <= ~accReg;
                OP_RC:           carryReg <= 1'b0;
                OP_SC:           carryReg <= 1'b1;
                OP_XOR:          accReg <= accReg ^ memNib;
                OP_LD: begin
                    accReg             <= memNib;
                    ram_row_select_reg <= ram_row_select_reg ^ instr.rsel;
                end
                OP_X: begin
                    accReg             <= memNib;
                    ram_row_select_reg <= ram_row_select_reg ^ instr.rsel;
                end
                OP_XIS: begin
                    accReg             <= memNib;
                    ram_row_select_reg <= ram_row_select_reg ^ instr.rsel;
                    digit_select_reg   <= digitUp;
                end
                OP_XDS: begin
                    accReg             <= memNib;
                    ram_row_select_reg <= ram_row_select_reg ^ instr.rsel;
                    digit_select_reg   <= digitDown;
                end
                OP_LBI: begin
                    ram_row_select_reg <= instr.rsel;
                    digit_select_reg   <= instr.imm;
                end
                OP_INL:          accReg <= portPinSync[7:4]; // [RULE8]
                OP_XAS:          accReg <= shift_count_reg; // [RULE10]
                default:         accReg <= accReg;
            endcase
        end
    end

    // Data memory: never cleared, so power-up contents are whatever the array held
    wire memWrite = step && (instr.op == OP_X || instr.op == OP_XIS
                          || instr.op == OP_XDS || instr.op == OP_INL);
    wire [3:0] memData = (instr.op == OP_INL) ? portPinSync[3:0] : accReg; // [RULE8]
    always_ff @(posedge clk_sys) begin
        if (memWrite) begin
            ramMem[ram_row_select_reg][physDigit] <= memData; // [RULE4] [RULE21]
        end
    end

    // General register, data out, enable register
    always_ff @(posedge clk_sys) begin
        if (doInit) begin
            feature_enable_reg <= 4'h0; // [RULE21]
            genReg             <= 4'h0;
            dataOutReg         <= 4'h0;
        end else if (step) begin
            case (instr.op)
                OP_LEI:  feature_enable_reg <= instr.imm; // [RULE11]
                OP_OMG:  genReg <= memNib;
                OP_LDATA: dataOutReg <= accReg;
                default: genReg <= genReg;
            endcase
        end
    end

    // Cleared on power-on reset only; the reset pin leaves the latch as it was
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            portLatchReg <= 8'h00;
        end else if (step && instr.op == OP_CAMQ) begin
            portLatchReg <= {accReg, memNib}; // [RULE8]
        end else if (step && instr.op == OP_LQID) begin
            portLatchReg <= instr.romData; // [RULE8]
        end
    end

    // Serial unit. Counter edges come from the synchronised pin, so pulses
    // narrower than the filter are lost; that is why two-cycle pulses are needed.
    wire siFall = siPrevReg && !serialInSync; // [RULE13]
    always_ff @(posedge clk_sys) begin
        // Idle level of the pin, so no false count follows reset
        if (rst) begin
            siPrevReg <= 1'b1;
        end else begin
            siPrevReg <= serialInSync;
        end
        if (doInit) begin
            clock_out_latch_reg <= 1'b1; // [RULE22]
        end else if (step && instr.op == OP_XAS) begin
            clock_out_latch_reg <= carryReg; // [RULE10]
        end
        if (step && instr.op == OP_XAS) begin
            shift_count_reg <= accReg; // [RULE10]
        end else if (cntMode && siFall) begin
            shift_count_reg <= shift_count_reg - 4'h1; // [RULE12]
        end else if (!cntMode && cycleStb) begin
            shift_count_reg <= {shift_count_reg[2:0], serialInSync}; // [RULE15]
        end
    end

    // Pin outputs, all registered
    wire soNext = cntMode ? soEnable : (soEnable && shift_count_reg[3]); // [RULE14] [RULE17]
    wire skNext = cntMode ? clock_out_latch_reg : (clock_out_latch_reg && halfHigh); // [RULE14] [RULE16]

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            portPins      <= '0;
            genPinOut     <= 4'h0;
            genPinOe      <= 4'h0;
            dataOut       <= 4'h0;
            serialOutPin  <= 1'b0;
            clock_out_pin <= 1'b0;
            romAddr       <= PC_RESET;
            skipNext      <= 1'b0;
            cycleDone     <= 1'b0;
            initReg       <= 1'b1;
        end else begin
            portPins.out  <= portLatchReg;
            portPins.oe   <= {8{portDrv}}; // [RULE19] [RULE8]
            genPinOut     <= genReg; // [RULE9]
            genPinOe      <= ~genReg;
            dataOut       <= dataOutReg;
            serialOutPin  <= soNext;
            clock_out_pin <= skNext;
            romAddr       <= pcReg;
            skipNext      <= skipReg;
            cycleDone     <= cycleStb;
            initReg       <= initTrig || (initReg && !cycleStb);
        end
    end
endmodule

// >>> rtl/nmc_cycle_div.sv
// Instruction cycle divider: one-cycle strobe every 4 or 8 oscillator ticks
`timescale 1ns/10ps
module nmc_cycle_div
    import nmc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic divBy8,
    output logic      cycleStb,
    output logic      halfHigh
);
    logic [2:0] cntReg;
    wire  [2:0] lastCount = divBy8 ? 3'(OSC_DIV_RES - 1) : 3'(OSC_DIV_EXT - 1); // [RULE23]
    wire  [2:0] halfCount = divBy8 ? 3'(OSC_DIV_RES / 2) : 3'(OSC_DIV_EXT / 2);

    always_ff @(posedge clk_sys) begin
        if (rst || cntReg >= lastCount) begin
            cntReg <= 3'h0;
        end else begin
            cntReg <= cntReg + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        cycleStb <= !rst && (cntReg == lastCount);
        halfHigh <= !rst && (cntReg < halfCount);
    end
endmodule

// >>> rtl/nmc_pkg.sv
// Package: constants and carrier types for the nibble core serial I/O block
package nmc_pkg;
    localparam int PC_W         = 9;
    localparam int PAGE_W       = 6;
    localparam int ROW_W        = 2;
    localparam int DIGIT_W      = 4;
    localparam int DIGITS       = 8;
    localparam int ROWS         = 4;
    localparam int EN_CNT_BIT   = 0;
    localparam int EN_UNUSED    = 1;
    localparam int EN_LDRV_BIT  = 2;
    localparam int EN_SO_BIT    = 3;
    localparam logic [3:0] NIB_ZERO  = 4'h0;
    localparam logic [3:0] NIB_MAX   = 4'hF;
    localparam logic [8:0] PC_RESET  = 9'h000;
    localparam logic [2:0] JSRP_PAGE = 3'h2;
    localparam int OSC_DIV_RES  = 8;
    localparam int OSC_DIV_EXT  = 4;
    localparam int RESET_LOW_CYCLES = 3;

    // Instruction operations decoded upstream of this block
    typedef enum logic [4:0] {
        OP_NOP, OP_ASC, OP_ADD, OP_AISC, OP_CLRA, OP_COMP, OP_RC, OP_SC, OP_XOR,
        OP_JMP, OP_JP, OP_JSRP, OP_JSR, OP_RET, OP_RETSK, OP_JID,
        OP_CAMQ, OP_LQID, OP_LD, OP_X, OP_XIS, OP_XDS, OP_LBI,
        OP_XAS, OP_LEI, OP_OMG, OP_INL, OP_LDATA
    } nmc_op_t;

    typedef struct packed {
        nmc_op_t     op;
        logic [8:0]  addr;
        logic [3:0]  imm;
        logic [1:0]  rsel;
        logic [7:0]  romData;
    } nmc_instr_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } nmc_port8_t;
endpackage

// >>> rtl/nmc_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module nmc_sync3 (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      level
);
    logic s1Reg;
    logic s2Reg;
    logic s3Reg;

    always_ff @(posedge clk_sys) begin
        s1Reg <= pinIn;
        s2Reg <= s1Reg;
        s3Reg <= s2Reg;
        if (rst) begin
            level <= 1'b1;
        end else if (s2Reg == s3Reg) begin
            level <= s3Reg;
        end
    end
endmodule

// >>> tb/nibble_mcu_core_serial_io_bench.sv
// Testbench: instruction sequences against the nibble core
`timescale 1ns/10ps
module nibble_mcu_core_serial_io_bench;
    import nmc_pkg::*;
    logic       clk_sys, rst, divBy8, resetPinN, instrValid, serialInPin;
    logic       serialOutPin, clock_out_pin, skipNext, cycleDone;
    logic [7:0] portPinIn, skRises, skMark;
    logic [3:0] genPinIn, genPinOut, genPinOe, dataOut;
    logic [8:0] romAddr, pcSeen;
    nmc_instr_t instr;
    nmc_port8_t portPins;
    int         failures, checked;
    logic [3:0] bdv [3] = '{4'hF, 4'h7, 4'h0};
    logic       skv [3] = '{1'b1, 1'b0, 1'b1};

    nmc_core uut (.clk_sys, .rst, .divBy8, .resetPinN, .instr, .instrValid, .portPinIn,
        .genPinIn, .serialInPin, .portPins, .genPinOut, .genPinOe, .dataOut,
        .serialOutPin, .clock_out_pin, .romAddr, .skipNext, .cycleDone);
    nmc_serial_partner far (.clk_sys, .clock_out_pin, .serialInPin, .skRises);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One instruction, held until the core reports its cycle done
    task automatic run(input nmc_op_t o, input logic [3:0] im = 4'h0,
                       input logic [1:0] rs = 2'h0, input logic [8:0] a = 9'h000,
                       input logic [7:0] rd = 8'h00);
        int n;
        @(posedge clk_sys);
        instr <= '{op: o, addr: a, imm: im, rsel: rs, romData: rd};
        instrValid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            if (cycleDone === 1'b1)
                break;
        end
        if (n == 40) begin
            failures++;
            complete_run();
        end
        @(negedge clk_sys);
    endtask

    task automatic gap(input logic [8:0] exp);
        int n;
        run(OP_NOP);
        for (n = 1; n < 40; n++) begin
            @(posedge clk_sys);
            if (cycleDone === 1'b1)
                break;
        end
        check(16'(n), exp);
    endtask

    initial begin
        rst = 1'b1;
        divBy8 = 1'b0;
        resetPinN = 1'b1;
        instrValid = 1'b0;
        instr = '0;
        portPinIn = 8'hA5;
        genPinIn = 4'h0;
        failures = 0;
        checked = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        check({romAddr, genPinOut}, 16'h0000);
        check({portPins.oe, dataOut}, 16'h0000);
        repeat (2) run(OP_NOP);
        skMark = skRises;
        pcSeen = romAddr;
        repeat (4) run(OP_NOP);
        check(romAddr, pcSeen + 9'h004);
        check(8'(skRises - skMark), 8'h04);
        gap(9'h004);
        run(OP_JMP, 4'h0, 2'h0, 9'h1F0);
        check(romAddr, 9'h1F0);
        run(OP_JSR, 4'h0, 2'h0, 9'h0C5);
        run(OP_JSRP, 4'h0, 2'h0, 9'h012);
        check(romAddr, {JSRP_PAGE, 6'h12});
        run(OP_RET);
        check(romAddr, 9'h0C6);
        run(OP_RET);
        check(romAddr, 9'h1F1);
        run(OP_JP, 4'h0, 2'h0, 9'h00A);
        check(romAddr, 9'h1CA);
        run(OP_JID, 4'h0, 2'h0, 9'h000, 8'h77);
        check(romAddr, 9'h177);
        run(OP_JSR, 4'h0, 2'h0, 9'h0A0);
        run(OP_RETSK);
        check({romAddr, skipNext}, {9'h178, 1'b1});
        run(OP_NOP);
        run(OP_LQID, 4'h0, 2'h0, 9'h000, 8'h3C);
        check(portPins.out, 8'h3C);
        // Digit 3 and its alias 11 must hit the same cell
        run(OP_LBI, 4'h3, 2'h1);
        run(OP_CLRA);
        run(OP_AISC, 4'h5);
        run(OP_X);
        run(OP_LBI, 4'hB, 2'h1);
        run(OP_CAMQ);
        check(portPins.out[3:0], 4'h5);
        run(OP_OMG);
        check({genPinOe, genPinOut}, 8'hA5);
        run(OP_CLRA);
        run(OP_AISC, 4'hC);
        run(OP_SC);
        run(OP_ASC);
        check(skipNext, 1'b1);
        run(OP_NOP);
        run(OP_CAMQ);
        check(portPins.out[7:4], 4'h2);
        run(OP_LEI, 4'h6);
        check({portPins.oe, portPins.out[7:4]}, 12'hFF2);
        run(OP_LEI, 4'h2);
        check(portPins.oe, 8'h00);
        // Pin read, adder without carry, logic ops and row toggling
        run(OP_LBI, 4'h1, 2'h2);
        run(OP_INL);
        run(OP_CAMQ);
        check(portPins.out, 8'hA5);
        run(OP_ADD);
        run(OP_XOR);
        run(OP_COMP);
        run(OP_LDATA);
        check(dataOut, 4'h5);
        run(OP_LD, 4'h0, 2'h3);
        run(OP_X);
        run(OP_LBI, 4'h1, 2'h1);
        run(OP_CAMQ);
        check(portPins.out[3:0], 4'h5);
        for (int i = 0; i < 3; i++) begin
            run(OP_LBI, bdv[i]);
            run(i == 2 ? OP_XDS : OP_XIS);
            check(skipNext, skv[i]);
            run(OP_NOP);
        end
        run(OP_LEI, 4'h8);
        far.set_level(1'b1);
        run(OP_CLRA);
        run(OP_SC);
        run(OP_XAS);
        skMark = skRises;
        repeat (6) run(OP_NOP);
        check(serialOutPin, 1'b1);
        check(8'(skRises - skMark), 8'h06);
        run(OP_XAS);
        run(OP_CAMQ);
        check(portPins.out[7:4], 4'hF);
        run(OP_LEI, 4'h0);
        run(OP_NOP);
        check(serialOutPin, 1'b0);
        run(OP_RC);
        run(OP_XAS);
        skMark = skRises;
        repeat (4) run(OP_NOP);
        check({8'(skRises - skMark), clock_out_pin}, 9'h000);
        run(OP_LEI, 4'h9);
        run(OP_CLRA);
        run(OP_AISC, 4'h5);
        run(OP_SC);
        run(OP_XAS);
        run(OP_NOP);
        check({serialOutPin, clock_out_pin}, 2'h3);
        far.pulses(3, 24);
        run(OP_XAS);
        run(OP_CAMQ);
        check(portPins.out[7:4], 4'h2);
        run(OP_LEI, 4'h1);
        run(OP_RC);
        run(OP_XAS);
        run(OP_NOP);
        check({serialOutPin, clock_out_pin}, 2'h0);
        // A one-cycle low on the reset pin must not initialise
        run(OP_JMP, 4'h0, 2'h0, 9'h055);
        @(posedge clk_sys);
        resetPinN <= 1'b0;
        repeat (4) @(posedge clk_sys);
        resetPinN <= 1'b1;
        run(OP_NOP);
        check(romAddr, 9'h056);
        @(posedge clk_sys);
        resetPinN <= 1'b0;
        repeat (40) @(posedge clk_sys);
        @(negedge clk_sys);
        check(romAddr, 9'h000);
        check({portPins.oe, genPinOut, dataOut}, 16'h0000);
        @(posedge clk_sys);
        resetPinN <= 1'b1;
        repeat (2) run(OP_NOP);
        run(OP_LBI, 4'h3, 2'h1);
        run(OP_CAMQ);
        check(portPins.out[3:0], 4'h5);
        @(posedge clk_sys);
        rst <= 1'b1;
        divBy8 <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        run(OP_NOP);
        gap(9'h008);
        complete_run();
    end
endmodule

// >>> tb/nmc_core_props.sv
// Checker: timing and reset properties at the nibble core ports
`timescale 1ns/10ps
module nmc_core_props (
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic                divBy8,
    input wire nmc_pkg::nmc_port8_t portPins,
    input wire logic [3:0]          genPinOut,
    input wire logic [3:0]          dataOut,
    input wire logic                clock_out_pin,
    input wire logic [8:0]          romAddr,
    input wire logic                skipNext,
    input wire logic                cycleDone
);
    import nmc_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence gap4; !cycleDone [*3] ##1 cycleDone; endsequence
    sequence gap8; !cycleDone [*7] ##1 cycleDone; endsequence
    a_cycle_by_four: assert property (cycleDone && !divBy8 |=> gap4)
        else $error("cycle spacing not four clocks");
    a_cycle_by_eight: assert property (cycleDone && divBy8 |=> gap8)
        else $error("cycle spacing not eight clocks");
    // Outputs move one clock after the strobe, i.e. at the edge where cycleDone falls
    a_pc_stands: assert property (!$past(cycleDone) |-> $stable(romAddr))
        else $error("program address moved between cycles");
    a_skip_stands: assert property (!$past(cycleDone) |-> $stable(skipNext))
        else $error("skip flag moved between cycles");
    a_pins_stand: assert property (!$past(cycleDone) |-> $stable(portPins))
        else $error("port outputs moved between cycles");
    a_gen_stands: assert property (!$past(cycleDone) |-> $stable(genPinOut))
        else $error("general outputs moved between cycles");
    a_drive_uniform: assert property (portPins.oe == 8'h00 || portPins.oe == 8'hFF)
        else $error("parallel drivers not enabled as a group");
    a_sync_clear: assert property (disable iff (1'b0) rst |=> romAddr == 9'h000
        && portPins == 16'h0000 && genPinOut == 4'h0 && dataOut == 4'h0)
        else $error("outputs not cleared by reset");
    a_sync_after_reset: assert property ($fell(rst) |-> ##[1:40] $rose(clock_out_pin))
        else $error("no clock output pulse after reset");
endmodule
bind nmc_core nmc_core_props u_props (.clk_sys, .rst, .divBy8, .portPins, .genPinOut,
    .dataOut, .clock_out_pin, .romAddr, .skipNext, .cycleDone);

// >>> tb/nmc_serial_partner.sv
// Far side model: pulse source on the serial input, clock edge counter
`timescale 1ns/10ps
module nmc_serial_partner (
    input  wire logic  clk_sys,
    input  wire logic  clock_out_pin,
    output logic       serialInPin,
    output logic [7:0] skRises
);
    logic skPrev;
    initial begin
        serialInPin = 1'b1;
        skRises = 8'h00;
        skPrev = 1'b0;
    end
    // Rising edges only, so a level held high counts once
    always @(posedge clk_sys) begin
        skPrev <= clock_out_pin;
        if (clock_out_pin && !skPrev)
            skRises <= skRises + 8'h01;
    end
    task automatic set_level(input logic lvl);
        @(posedge clk_sys);
        serialInPin <= lvl;
    endtask
    // Each phase lasts w clocks; callers keep w at two cycles or more
    task automatic pulses(input int n, input int w);
        for (int i = 0; i < n; i++) begin
            repeat (w) @(posedge clk_sys);
            serialInPin <= 1'b0;
            repeat (w) @(posedge clk_sys);
            serialInPin <= 1'b1;
        end
    endtask
endmodule
